// >>> verilog/esr_status.v
`include "esr_regs.vh"
module esr_status #(
  parameter WC_CYCLES = `ESR_WC_CYCLES
) (
  input  wire        sys_clk_in,     // system clock, 125 MHz
  input  wire        rstn_in,        // power-on reset, active low
  input  wire        ce_in,          // clock enable
  input  wire        spi_csn_in,     // chip select, active low
  input  wire        spi_sck_in,     // serial clock (mode 0)
  input  wire        spi_si_in,      // serial data in
  input  wire        wp_n_in,        // write-protect pin, active low
  input  wire        rd_done_in,     // pulse: array read sequence ended
  input  wire        rd_corr_in,     // that read needed correction
  input  wire        uv_block_in,    // pulse: undervoltage blocked a write
  input  wire        part_prot_in,   // enhanced-mode protect verdict
  input  wire [12:0] arr_addr_in,    // array address to check
  input  wire [5:0]  sec_addr_in,    // security address to check
  output reg         spi_so_out,     // serial data out
  output reg         spi_so_oe_out,  // serial out enable
  output reg  [15:0] status_out,     // live status word
  output reg         arr_prot_out,   // array address protected
  output reg         sec_prot_out,   // security address protected
  output reg         range_ro_out,   // partition address fields read-only
  output reg         behav_ro_out,   // partition behaviour fields read-only
  output reg         nvcmd_out,      // pulse: accepted nv command opcode
  output reg  [7:0]  nvcmd_op_out    // opcode of that command
);
  localparam ST_CMD  = 3'h0;
  localparam ST_STATUS_READ_COMMAND = 3'h1;
  localparam ST_POLL = 3'h2;
  localparam ST_STATUS_WRITE_COMMAND = 3'h3;
  localparam ST_IGN  = 3'h4;
  localparam ST_NV   = 3'h5;
  localparam CW      = 32;

  wire [3:0] pin_s;
  wire       csn;
  wire       sck;
  wire       si;
  wire       wpn;
  reg        sck_d;
  reg        csn_d;
  reg  [2:0] state;
  reg  [2:0] bitcnt;
  reg  [1:0] bytecnt;
  reg  [7:0] sh_in;
  reg  [15:0] sh_out;
  reg  [15:0] nv_snap;
  reg  [7:0] wr_b0;
  reg  [7:0] wr_b1;
  reg  [7:0] nv_op;
  reg        protect_enable_bit;
  reg  [1:0] bp;
  reg        protection_mode_bit;
  reg        freeze_flag;
  reg        boundary_lock_bit;
  reg        write_enable_latch;
  reg        partition_write_latch;
  reg        correction_event_flag;
  reg        write_lockout_flag;
  reg        busy;
  reg  [CW-1:0] wc_cnt;
  reg        wc_is_status_write_command;
  reg        wc_b1_sent;
  reg        rd_on_b1;
  wire       sck_rise;
  wire       sck_fall;
  wire       cs_rise;
  wire       cs_fall;
  wire [7:0] byte_in;
  wire       hw_prot;
  wire       arr_p;
  wire       sec_p;
  wire [15:0] live;
  wire [15:0] rd_word;

  // pins are asynchronous to sys_clk
  esr_sync #(.W(4)) u_sync (
    .clk_in  (sys_clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .d_in    ({spi_csn_in, spi_sck_in, spi_si_in, wp_n_in}),
    .q_out   (pin_s)
  );
  assign csn = pin_s[3];
  assign sck = pin_s[2];
  assign si  = pin_s[1];
  assign wpn = pin_s[0];

  assign sck_rise = sck & ~sck_d & ~csn;
  assign sck_fall = ~sck & sck_d & ~csn;
  assign cs_rise  = csn & ~csn_d;
  assign cs_fall  = ~csn & csn_d;
  assign byte_in  = {sh_in[6:0], si};
  assign hw_prot  = ~wpn & protect_enable_bit;

  // assembled status word; busy mirrored into both bytes
  assign live = {protection_mode_bit, correction_event_flag, freeze_flag, partition_write_latch, boundary_lock_bit, write_lockout_flag, 1'b0, busy,
                 protect_enable_bit, 3'h0, bp, write_enable_latch, busy};
  // continued read: volatile bits refresh each byte, nonvolatile stay as snapped
  assign rd_word = {nv_snap[15], correction_event_flag, nv_snap[13], partition_write_latch, nv_snap[11], write_lockout_flag,
                    1'b0, busy, nv_snap[7:2], write_enable_latch, busy};

  esr_prot u_prot (
    .level_in     (bp),
    .mode_in      (protection_mode_bit),
    .part_prot_in (part_prot_in),
    .arr_addr_in  (arr_addr_in),
    .sec_addr_in  (sec_addr_in),
    .arr_prot_out (arr_p),
    .sec_prot_out (sec_p)
  );

  // edge history of the synchronised pins
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_d <= 1'b0;
      csn_d <= 1'b1;
    end else if (ce_in) begin
      sck_d <= sck;
      csn_d <= csn;
    end
  end

  // command decode, shifters and status flags
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state      <= ST_CMD;
      bitcnt     <= 3'h0;
      bytecnt    <= 2'h0;
      sh_in      <= 8'h00;
      sh_out     <= 16'h0000;
      nv_snap    <= 16'h0000;
      wr_b0      <= 8'h00;
      wr_b1      <= 8'h00;
      nv_op      <= 8'h00;
      protect_enable_bit       <= 1'b0;
      bp         <= 2'h0;
      protection_mode_bit        <= 1'b0;
      freeze_flag       <= 1'b0;
      boundary_lock_bit       <= 1'b0;
      write_enable_latch        <= 1'b0;
      partition_write_latch       <= 1'b0;
      correction_event_flag        <= 1'b0;
      write_lockout_flag        <= 1'b0;
      busy       <= 1'b0;
      wc_cnt     <= {CW{1'b0}};
      wc_is_status_write_command <= 1'b0;
      rd_on_b1   <= 1'b0;
      nvcmd_out  <= 1'b0;
      nvcmd_op_out <= 8'h00;
      spi_so_out <= 1'b0;
      spi_so_oe_out <= 1'b0;
    end else if (ce_in) begin
      nvcmd_out <= 1'b0;
      // self-timed write cycle
      if (busy) begin
        if (wc_cnt == WC_CYCLES[CW-1:0] - 1'b1) begin
          busy <= 1'b0;
          write_enable_latch  <= 1'b0;
          if (wc_is_status_write_command) begin
            protect_enable_bit <= wr_b0[`ESR_B_PROTECT_ENABLE_BIT];
            bp   <= {wr_b0[`ESR_B_BP1], wr_b0[`ESR_B_BP0]};
            if (wc_b1_sent && !freeze_flag)
              protection_mode_bit <= wr_b1[7];
          end else if (nv_op == `ESR_OP_FREEZE_COMMAND) begin
            freeze_flag <= 1'b1;
          end else if (nv_op == `ESR_OP_BOUNDARY_PROTECT_COMMAND) begin
            boundary_lock_bit <= wr_b0[0];
          end
        end else begin
          wc_cnt <= wc_cnt + 1'b1;
        end
      end
      // write data is kept across frames: a status read during the cycle must not lose it
      if (cs_fall) begin
        state   <= ST_CMD;
        bitcnt  <= 3'h0;
        bytecnt <= 2'h0;
      end
      if (sck_rise) begin
        sh_in  <= byte_in;
        bitcnt <= bitcnt + 1'b1;
        if (bitcnt == 3'h7) begin
          if (bytecnt != 2'h3)
            bytecnt <= bytecnt + 1'b1;
          case (state)
            ST_CMD: begin
              if (busy && byte_in != `ESR_OP_STATUS_READ_COMMAND && byte_in != `ESR_OP_BUSY_POLL_COMMAND) begin
                state <= ST_IGN;
              end else begin
                case (byte_in)
                  `ESR_OP_STATUS_READ_COMMAND: begin
                    state    <= ST_STATUS_READ_COMMAND;
                    nv_snap  <= live;
                    sh_out   <= live;
                    rd_on_b1 <= 1'b1;
                  end
                  `ESR_OP_BUSY_POLL_COMMAND: begin
                    state  <= ST_POLL;
                    sh_out <= {busy ? `ESR_POLL_BUSY : `ESR_POLL_READY, 8'h00};
                  end
                  `ESR_OP_WRITE_ENABLE_COMMAND: begin
                    write_enable_latch   <= 1'b1;
                    state <= ST_IGN;
                  end
                  `ESR_OP_WRITE_DISABLE_COMMAND: begin
                    write_enable_latch   <= 1'b0;
                    state <= ST_IGN;
                  end
                  `ESR_OP_PARTITION_WRITE_ENABLE_COMMAND: begin
                    if (write_enable_latch)
                      partition_write_latch <= 1'b1;
                    state <= ST_IGN;
                  end
                  `ESR_OP_PARTITION_WRITE_DISABLE_COMMAND: begin
                    partition_write_latch  <= 1'b0;
                    state <= ST_IGN;
                  end
                  `ESR_OP_SOFTWARE_RESET_COMMAND: begin
                    write_enable_latch   <= 1'b0;
                    partition_write_latch  <= 1'b0;
                    correction_event_flag   <= 1'b0;
                    write_lockout_flag   <= 1'b0;
                    state <= ST_IGN;
                  end
                  `ESR_OP_STATUS_WRITE_COMMAND: begin
                    write_lockout_flag   <= 1'b0;
                    state <= (write_enable_latch && !hw_prot) ? ST_STATUS_WRITE_COMMAND : ST_IGN;
                  end
                  `ESR_OP_FREEZE_COMMAND, `ESR_OP_BOUNDARY_PROTECT_COMMAND, `ESR_OP_PARTITION_WRITE_COMMAND, `ESR_OP_UNDERVOLTAGE_CONFIG_COMMAND: begin
                    write_lockout_flag   <= 1'b0;
                    nv_op <= byte_in;
                    state <= (write_enable_latch && !hw_prot && !freeze_flag) ? ST_NV : ST_IGN;
                  end
                  `ESR_OP_WRITE: begin
                    write_lockout_flag   <= 1'b0;
                    state <= ST_IGN;
                  end
                  default: state <= ST_IGN;
                endcase
              end
            end
            ST_STATUS_READ_COMMAND: begin
              // bytes alternate byte 1, byte 0; the next one goes into the upper half
              sh_out   <= rd_on_b1 ? {rd_word[7:0], rd_word[15:8]} : rd_word;
              rd_on_b1 <= ~rd_on_b1;
            end
            ST_POLL: sh_out <= {busy ? `ESR_POLL_BUSY : `ESR_POLL_READY, 8'h00};
            ST_STATUS_WRITE_COMMAND: begin
              if (bytecnt == 2'h1)
                wr_b0 <= byte_in;
              else if (bytecnt == 2'h2)
                wr_b1 <= byte_in;
            end
            ST_NV: if (bytecnt == 2'h1) wr_b0 <= byte_in;
            default: state <= state;
          endcase
        end
      end
      // shift out on falling edge, msb first; the byte in flight sits in sh_out[15:8]
      if (sck_fall && (state == ST_STATUS_READ_COMMAND || state == ST_POLL)) begin
        spi_so_out    <= sh_out[4'hf - {1'b0, bitcnt}];
        spi_so_oe_out <= 1'b1;
      end
      // frame end: start cycle only at a byte boundary after a whole frame
      if (cs_rise) begin
        spi_so_oe_out <= 1'b0;
        state <= ST_CMD;
        if (bitcnt == 3'h0 && !busy) begin
          if (state == ST_STATUS_WRITE_COMMAND && bytecnt >= 2'h2) begin
            busy       <= 1'b1;
            wc_cnt     <= {CW{1'b0}};
            wc_is_status_write_command <= 1'b1;
            nvcmd_out  <= 1'b1;
            nvcmd_op_out <= `ESR_OP_STATUS_WRITE_COMMAND;
          end else if (state == ST_NV && bytecnt >= 2'h1 &&
                       (nv_op == `ESR_OP_FREEZE_COMMAND || nv_op == `ESR_OP_BOUNDARY_PROTECT_COMMAND ? partition_write_latch : 1'b1)) begin
            busy       <= 1'b1;
            wc_cnt     <= {CW{1'b0}};
            wc_is_status_write_command <= 1'b0;
            nvcmd_out  <= 1'b1;
            nvcmd_op_out <= nv_op;
          end
        end
      end
      // read outcome after the soft reset clear, so a correction set wins
      if (rd_done_in)
        correction_event_flag <= rd_corr_in;
      // undervoltage block wins over any clear this cycle
      if (uv_block_in)
        write_lockout_flag <= 1'b1;
    end
  end

  // byte 1 counts only if it was actually sent; latched at the frame end
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      wc_b1_sent <= 1'b0;
    else if (ce_in && cs_rise && state == ST_STATUS_WRITE_COMMAND)
      wc_b1_sent <= (bytecnt == 2'h3);
  end

  // registered views for the array datapath
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out   <= 16'h0000;
      arr_prot_out <= 1'b0;
      sec_prot_out <= 1'b0;
      range_ro_out <= 1'b0;
      behav_ro_out <= 1'b0;
    end else if (ce_in) begin
      status_out   <= live;
      arr_prot_out <= arr_p;
      sec_prot_out <= sec_p;
      range_ro_out <= boundary_lock_bit | freeze_flag | hw_prot;
      behav_ro_out <= freeze_flag | hw_prot;
    end
  end
endmodule // esr_status

// >>> verilog/esr_regs.vh
`ifndef ESR_REGS_VH
`define ESR_REGS_VH
// command opcodes
`define ESR_OP_WRITE_ENABLE_COMMAND      8'h06
`define ESR_OP_WRITE_DISABLE_COMMAND      8'h04
`define ESR_OP_STATUS_READ_COMMAND      8'h05
`define ESR_OP_STATUS_WRITE_COMMAND      8'h01
`define ESR_OP_BUSY_POLL_COMMAND      8'h08
`define ESR_OP_FREEZE_COMMAND      8'h0d
`define ESR_OP_PARTITION_WRITE_ENABLE_COMMAND      8'h0e
`define ESR_OP_PARTITION_WRITE_DISABLE_COMMAND      8'h0f
`define ESR_OP_BOUNDARY_PROTECT_COMMAND      8'h09
`define ESR_OP_SOFTWARE_RESET_COMMAND      8'h7c
`define ESR_OP_PARTITION_WRITE_COMMAND      8'h12
`define ESR_OP_UNDERVOLTAGE_CONFIG_COMMAND      8'h1c
`define ESR_OP_WRITE     8'h02
// status field positions (16-bit word, byte 0 in [7:0], byte 1 in [15:8])
`define ESR_B_BUSY0      0
`define ESR_B_WEL        1
`define ESR_B_BP0        2
`define ESR_B_BP1        3
`define ESR_B_PROTECT_ENABLE_BIT       7
`define ESR_B_BUSY1      8
`define ESR_B_WLS        10
`define ESR_B_BOUNDARY_LOCK_BIT       11
`define ESR_B_PARTITION_WRITE_LATCH       12
`define ESR_B_FREEZE_FLAG       13
`define ESR_B_ECS        14
`define ESR_B_WPM        15
// poll answers
`define ESR_POLL_BUSY    8'hff
`define ESR_POLL_READY   8'h00
// protected ranges
`define ESR_RANGE_Q_LO   13'h1800
`define ESR_RANGE_H_LO   13'h1000
`define ESR_SEC_LOW_TOP  6'h1f
`define ESR_ARRAY_TOP    13'h1fff
`define ESR_SEC_TOP      6'h3f
// write cycle default in sys clocks
`define ESR_WC_CYCLES    500000
`endif

// >>> verilog/esr_sync.v
// two-flop synchroniser, one per bit
module esr_sync #(
  parameter W = 1
) (
  input  wire         clk_in,   // sampling clock
  input  wire         rstn_in,  // async reset, active low
  input  wire         ce_in,    // clock enable
  input  wire [W-1:0] d_in,     // asynchronous inputs
  output wire [W-1:0] q_out     // synchronised inputs
);
  reg [W-1:0] meta;
  reg [W-1:0] stab;
  genvar i;
  // first stage feeds only the second one
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          meta[i] <= 1'b0;
          stab[i] <= 1'b0;
        end else if (ce_in) begin
          meta[i] <= d_in[i];
          stab[i] <= meta[i];
        end
      end
    end
  endgenerate
  assign q_out = stab;
endmodule // esr_sync

// >>> verilog/esr_prot.v
`include "esr_regs.vh"
// address protection decode for array and security page
module esr_prot (
  input  wire [1:0]  level_in,     // block-protect level
  input  wire        mode_in,      // protection_mode_bit
  input  wire        part_prot_in, // enhanced-mode verdict from partitions
  input  wire [12:0] arr_addr_in,  // array address
  input  wire [5:0]  sec_addr_in,  // security register address
  output reg         arr_prot_out, // array address protected
  output reg         sec_prot_out  // security address protected
);
  // legacy decode only when mode bit is 0, else partition verdict
  always @* begin
    arr_prot_out = 1'b0;
    sec_prot_out = (sec_addr_in <= `ESR_SEC_LOW_TOP);
    if (mode_in) begin
      arr_prot_out = part_prot_in;
      sec_prot_out = part_prot_in;
    end else begin
      case (level_in)
        2'h1: arr_prot_out = (arr_addr_in >= `ESR_RANGE_Q_LO);
        2'h2: arr_prot_out = (arr_addr_in >= `ESR_RANGE_H_LO);
        2'h3: begin
          arr_prot_out = (arr_addr_in <= `ESR_ARRAY_TOP);
          sec_prot_out = (sec_addr_in <= `ESR_SEC_TOP);
        end
        default: arr_prot_out = 1'b0;
      endcase
    end
  end
endmodule // esr_prot

// >>> verification/esr_chk_sva.sv
`include "esr_regs.vh"
module esr_chk #(
  parameter int WC_CYCLES = 600
) (
  input logic        sys_clk_in,    // clock
  input logic        rstn_in,       // reset, active low
  input logic        ce_in,         // clock enable
  input logic        spi_csn_in,    // chip select
  input logic        spi_sck_in,    // serial clock
  input logic        spi_si_in,     // serial in
  input logic        wp_n_in,       // protect pin
  input logic        rd_done_in,    // read ended
  input logic        rd_corr_in,    // read corrected
  input logic        uv_block_in,   // undervoltage block
  input logic        part_prot_in,  // partition verdict
  input logic [12:0] arr_addr_in,   // array address
  input logic [5:0]  sec_addr_in,   // security address
  input logic        spi_so_out,    // serial out
  input logic        spi_so_oe_out, // serial out enable
  input logic [15:0] status_out,    // status word
  input logic        arr_prot_out,  // array verdict
  input logic        sec_prot_out,  // security verdict
  input logic        range_ro_out,  // ranges read-only
  input logic        behav_ro_out,  // behaviour read-only
  input logic        nvcmd_out,     // cycle start
  input logic [7:0]  nvcmd_op_out   // its opcode
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic exp_arr;
  logic exp_sec;
  int   busy_cnt;

  // legacy verdicts from the shown level and the addresses
  always_comb begin
    exp_arr = (status_out[3:2] == 2'h3) || (status_out[3:2] == 2'h2 && arr_addr_in >= 13'h1000)
      || (status_out[3:2] == 2'h1 && arr_addr_in >= 13'h1800);
    exp_sec = (status_out[3:2] == 2'h3) || (sec_addr_in <= 6'h1f);
  end

  // busy length is only visible at the pins as a count of enabled clocks
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt <= 0;
    end else if (!status_out[0]) begin
      busy_cnt <= 0;
    end else if (ce_in) begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  a_busy_mirror: assert property (status_out[0] == status_out[8])
    else $error("busy flag differs between status bytes");
  a_busy_start: assert property (nvcmd_out |-> ##[0:2] status_out[0])
    else $error("write cycle start without busy");
  a_busy_len: assert property ($fell(status_out[0]) |->
    busy_cnt >= WC_CYCLES - 1 && busy_cnt <= WC_CYCLES + 1)
    else $error("busy length differs from cycle parameter");
  a_wel_clear: assert property ($fell(status_out[0]) |-> !status_out[1])
    else $error("write enable latch survives cycle end");
  a_arr_legacy: assert property ((!status_out[15] && $stable(status_out[3:2])
    && $stable(arr_addr_in)) [*3] |-> arr_prot_out == exp_arr)
    else $error("legacy array verdict wrong");
  a_sec_legacy: assert property ((!status_out[15] && $stable(status_out[3:2])
    && $stable(sec_addr_in)) [*3] |-> sec_prot_out == exp_sec)
    else $error("legacy security verdict wrong");
  a_arr_enhanced: assert property ((status_out[15] && $stable(part_prot_in)) [*3]
    |-> arr_prot_out == part_prot_in)
    else $error("enhanced array verdict ignores partitions");
  a_fields_ro: assert property ((status_out[13] || status_out[11]) [*3] |->
    range_ro_out && (behav_ro_out || !status_out[13]))
    else $error("partition fields writable while locked");
  a_freeze_sticky: assert property (status_out[13] |=>
    status_out[13] && $stable(status_out[15]))
    else $error("frozen configuration changed");
  a_oe_idle: assert property (spi_csn_in [*8] |-> !spi_so_oe_out)
    else $error("serial out driven while deselected");
  a_ecs_set: assert property (rd_done_in && rd_corr_in |-> ##[1:4] status_out[14])
    else $error("correction flag not set");
  a_wls_set: assert property (uv_block_in |-> ##[1:4] status_out[10])
    else $error("lockout flag not set");
  a_status_write_command_gated: assert property (nvcmd_out && nvcmd_op_out == `ESR_OP_STATUS_WRITE_COMMAND |->
    $past(status_out[1]) && !$past(status_out[0]))
    else $error("status write started without latch or while busy");
endmodule // esr_chk

bind esr_status esr_chk #(.WC_CYCLES(WC_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .spi_csn_in(spi_csn_in),
  .spi_sck_in(spi_sck_in), .spi_si_in(spi_si_in), .wp_n_in(wp_n_in), .rd_done_in(rd_done_in),
  .rd_corr_in(rd_corr_in), .uv_block_in(uv_block_in), .part_prot_in(part_prot_in),
  .arr_addr_in(arr_addr_in), .sec_addr_in(sec_addr_in), .spi_so_out(spi_so_out),
  .spi_so_oe_out(spi_so_oe_out), .status_out(status_out), .arr_prot_out(arr_prot_out),
  .sec_prot_out(sec_prot_out), .range_ro_out(range_ro_out), .behav_ro_out(behav_ro_out),
  .nvcmd_out(nvcmd_out), .nvcmd_op_out(nvcmd_op_out));

// >>> verification/esr_host.sv
module esr_host (
  input  wire  clk_in,  // bench system clock
  input  wire  so_in,   // serial data from device
  output logic csn_out, // chip select, active low
  output logic sck_out, // serial clock, mode 0
  output logic si_out   // serial data to device
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    csn_out = 1'b1;
    sck_out = 1'b0;
    si_out  = 1'b0;
  end

  // half a link period is five system clocks, so every edge lands on a falling clock edge
  task automatic half_bit;
    repeat (5) @(negedge clk_in);
  endtask

  // one framed transfer, msb first; so is taken late in the high phase, after the device moved
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    csn_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = tx[i];
      half_bit();
      sck_out = 1'b1;
      half_bit();
      rx = {rx[62:0], so_in};
      sck_out = 1'b0;
    end
    half_bit();
    csn_out = 1'b1;
    si_out  = ~si_out; // released line must not keep the last level
    half_bit();
  endtask
endmodule // esr_host

// >>> verification/esr_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 600;

  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        wp_n_in = 1'b1;
  logic        rd_done_in = 1'b0;
  logic        rd_corr_in = 1'b0;
  logic        uv_block_in = 1'b0;
  logic        part_prot_in = 1'b0;
  logic [12:0] arr_addr_in = 13'h0000;
  logic [5:0]  sec_addr_in = 6'h00;
  wire         csn, sck, si, so, so_oe, so_line;
  wire  [15:0] status;
  wire         arr_prot, sec_prot, rng_ro, beh_ro;
  wire  [7:0]  nv_op;
  logic [15:0] v;
  logic [63:0] r;
  int          n_errors = 0;
  int          check_count = 0;
  logic [12:0] arr_pts [6] = '{13'h0000, 13'h0fff, 13'h1000, 13'h17ff, 13'h1800, 13'h1fff};
  logic [5:0]  sec_pts [6] = '{6'h00, 6'h1f, 6'h20, 6'h3f, 6'h10, 6'h30};

  always #4 sys_clk_in = ~sys_clk_in;
  // undriven serial out shows the inverse of its last level
  assign so_line = so_oe ? so : ~so;

  esr_host host (.clk_in(sys_clk_in), .so_in(so_line), .csn_out(csn), .sck_out(sck),
    .si_out(si));
  esr_status #(.WC_CYCLES(WC)) DUT (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .spi_csn_in(csn),
    .spi_sck_in(sck), .spi_si_in(si), .wp_n_in(wp_n_in), .rd_done_in(rd_done_in),
    .rd_corr_in(rd_corr_in), .uv_block_in(uv_block_in), .part_prot_in(part_prot_in),
    .arr_addr_in(arr_addr_in), .sec_addr_in(sec_addr_in), .spi_so_out(so),
    .spi_so_oe_out(so_oe), .status_out(status), .arr_prot_out(arr_prot),
    .sec_prot_out(sec_prot), .range_ro_out(rng_ro), .behav_ro_out(beh_ro), .nvcmd_out(),
    .nvcmd_op_out(nv_op));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // command helpers over the serial frame
  task automatic cmd(input logic [7:0] op);
    host.frame(8, {56'h0, op}, r);
  endtask
  task automatic status_read_command(output logic [15:0] s);
    host.frame(24, {40'h0, 8'h05, 16'h0}, r);
    s = r[15:0];
  endtask
  task automatic wait_ready;
    repeat (8) @(negedge sys_clk_in);
    for (int i = 0; i < 2000 && status[0] !== 1'b0; i++) @(negedge sys_clk_in);
    chk(status[0], 1'b0, "ready after write cycle");
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge sys_clk_in);
    sig = 1'b0;
    repeat (6) @(negedge sys_clk_in);
  endtask

  // watchdog well beyond the expected run of about 110 us
  initial begin
    #500us;
    n_errors++;
    $display("FAIL %0t run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    status_read_command(v); chk(v, 16'h0000, "status after reset");
    host.frame(16, {48'h0, 8'h01, 8'h0c}, r);
    status_read_command(v); chk(v, 16'h0000, "status write without latch");
    cmd(8'h06); status_read_command(v); chk(v, 16'h0002, "latch set");
    wp_n_in = 1'b0;
    cmd(8'h04); status_read_command(v); chk(v, 16'h0000, "latch cleared under pin");
    wp_n_in = 1'b1;
    cmd(8'h06); host.frame(15, {49'h0, 8'h01, 7'h06}, r);
    status_read_command(v); chk(v, 16'h0002, "aborted status write");
    // every block-protect level, with the read-only bits written as ones
    for (int lv = 0; lv < 4; lv++) begin
      cmd(8'h06);
      host.frame(16, {48'h0, 8'h01, 4'h7, lv[1:0], 2'h3}, r);
      wait_ready();
      status_read_command(v); chk(v, {12'h000, lv[1:0], 2'h0}, "level written");
      for (int a = 0; a < 6; a++) begin
        arr_addr_in = arr_pts[a];
        sec_addr_in = sec_pts[a];
        repeat (4) @(negedge sys_clk_in);
        chk(arr_prot, lv == 3 || (lv == 2 && arr_pts[a] >= 13'h1000) ||
          (lv == 1 && arr_pts[a] >= 13'h1800), "array verdict");
        chk(sec_prot, lv == 3 || sec_pts[a] <= 6'h1f, "security verdict");
      end
    end
    // two-byte write, then status read, refused command and poll while busy
    cmd(8'h06); host.frame(24, {40'h0, 8'h01, 8'hff, 8'hff}, r);
    status_read_command(v); chk(v, 16'h010f, "status while busy");
    cmd(8'h0e);
    host.frame(40, {24'h0, 8'h08, 32'h0}, r);
    chk(r[31:24], 8'hff, "poll while busy");
    chk(r[7:0], 8'h00, "poll refreshed after cycle");
    wait_ready();
    host.frame(40, {24'h0, 8'h05, 32'h0}, r);
    chk(r[31:0], 32'h808c808c, "continued status read");
    part_prot_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk(arr_prot, 1'b1, "enhanced verdict set");
    part_prot_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk(arr_prot, 1'b0, "enhanced verdict clear");
    cmd(8'h0e); status_read_command(v); chk(v, 16'h808c, "partition latch needs write latch");
    cmd(8'h06); cmd(8'h0e); status_read_command(v); chk(v, 16'h908e, "partition latch set");
    cmd(8'h0f); status_read_command(v); chk(v, 16'h808e, "partition latch cleared");
    wp_n_in = 1'b0;
    host.frame(16, {48'h0, 8'h01, 8'h00}, r);
    host.frame(16, {48'h0, 8'h08, 8'h00}, r);
    chk(r[7:0], 8'h00, "no cycle under hardware protect");
    status_read_command(v); chk(v, 16'h808e, "status kept under hardware protect");
    wp_n_in = 1'b1;
    rd_corr_in = 1'b1;
    pulse(rd_done_in);
    pulse(uv_block_in);
    chk(status[14], 1'b1, "correction flag set");
    chk(status[10], 1'b1, "lockout flag set");
    rd_corr_in = 1'b0;
    pulse(rd_done_in);
    chk(status[14], 1'b0, "correction flag cleared by clean read");
    cmd(8'h7c); repeat (6) @(negedge sys_clk_in);
    chk(status, 16'h808c, "software reset clears volatile flags");
    // boundary lock, then freeze, then a status write that tries to leave enhanced mode
    cmd(8'h06); cmd(8'h0e); host.frame(16, {48'h0, 8'h09, 8'h01}, r);
    chk(nv_op, 8'h09, "boundary protect cycle started");
    wait_ready();
    status_read_command(v); chk(v, 16'h988c, "boundary lock set");
    chk(rng_ro, 1'b1, "address fields locked");
    chk(beh_ro, 1'b0, "behaviour fields still writable");
    cmd(8'h06); cmd(8'h0d);
    chk(nv_op, 8'h0d, "freeze cycle started");
    wait_ready();
    chk(beh_ro, 1'b1, "behaviour fields frozen");
    status_read_command(v); chk(v, 16'hb88c, "freeze flag set");
    cmd(8'h06); host.frame(24, {40'h0, 8'h01, 8'h8c, 8'h00}, r);
    chk(nv_op, 8'h01, "status write cycle started");
    wait_ready();
    status_read_command(v); chk(v, 16'hb88c, "protection mode frozen");
    tally_and_finish();
  end
endmodule // testbench
